// ===== dv/bms_boot_mode_selector_assertions.sv
// checker for the boot mode selector ports
// assumes: one clock, synchronous active-low resetn, bound onto the top
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"
// =====================================================================
// port checker
module bms_sel_checker (
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       external_reset_input,
  input wire logic       boot_strap_high,
  input wire logic       boot_strap_low,
  input wire logic       uart_receive_line,
  input wire logic       first_can_receive_line,
  input wire logic [2:0] boot_mode_q,
  input wire logic       fetch_to_test_flash_q,
  input wire logic [1:0] loader_channel_q,
  input wire logic       loader_start_q,
  input wire logic       software_reset_q,
  input wire logic       boot_done_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // decode lands two edges after the reset rise
  a_user_decode: assert property (
    $rose(external_reset_input) && boot_strap_high && boot_strap_low
    |-> ##2 boot_mode_q == `BMS_MODE_USER && !fetch_to_test_flash_q)
    else $error("user decode wrong");
  a_std_decode: assert property (
    $rose(external_reset_input) && boot_strap_high && !boot_strap_low
    |-> ##2 boot_mode_q == `BMS_MODE_STD && fetch_to_test_flash_q)
    else $error("standard decode wrong");
  a_sel_decode: assert property (
    $rose(external_reset_input) && !boot_strap_high && boot_strap_low
    |-> ##2 boot_mode_q == `BMS_MODE_SEL && fetch_to_test_flash_q)
    else $error("selective decode wrong");
  // the mode only moves as the answer to a reset rise
  a_mode_latched: assert property (
    $changed(boot_mode_q)
    |-> $past(external_reset_input, 2) && !$past(external_reset_input, 3))
    else $error("mode moved without reset rise");
  // first activity wins; uart wins a same-cycle tie; the mode shown in the
  // two edges after a rise may still be the one of the previous run
  a_uart_first: assert property (
    boot_mode_q == `BMS_MODE_STD && !boot_done_q && external_reset_input
    && $past(external_reset_input) && $past(external_reset_input, 2)
    && $fell(uart_receive_line)
    |=> loader_channel_q == `BMS_CHAN_UART && loader_start_q && boot_done_q)
    else $error("uart not picked");
  a_can_first: assert property (
    boot_mode_q == `BMS_MODE_STD && !boot_done_q && external_reset_input
    && $past(external_reset_input) && $past(external_reset_input, 2)
    && uart_receive_line && $fell(first_can_receive_line)
    |=> loader_channel_q == `BMS_CHAN_CAN && loader_start_q && boot_done_q)
    else $error("can not picked");
  a_chan_held: assert property (
    boot_done_q && external_reset_input |=> $stable(loader_channel_q))
    else $error("channel changed after choice");
  a_start_pulse: assert property (
    loader_start_q |=> !loader_start_q)
    else $error("start longer than one cycle");
  a_srst_width: assert property (
    $rose(software_reset_q) |-> software_reset_q [*4] ##1 !software_reset_q
    ##[0:2] (boot_done_q && !fetch_to_test_flash_q))
    else $error("software reset sequence wrong");
endmodule
// =====================================================================
bind bms_boot_mode_selector bms_sel_checker bms_sel_checker_inst (
  .sys_clk, .resetn, .external_reset_input, .boot_strap_high,
  .boot_strap_low, .uart_receive_line, .first_can_receive_line,
  .boot_mode_q, .fetch_to_test_flash_q, .loader_channel_q,
  .loader_start_q, .software_reset_q, .boot_done_q
);
`default_nettype wire

// ===== dv/bms_host_loader.sv
// host loader model on the uart and can receive lines
// assumes: lines idle high, opened on request from the bench
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// host side of the loader link
module bms_host_loader #(
  parameter int BIT_CYC = 8
) (
  input  wire logic sys_clk,
  output var  logic uart_receive_line,
  output var  logic first_can_receive_line
);
  // lines rest at their recessive/idle level
  initial begin
    uart_receive_line = 1'b1;
    first_can_receive_line = 1'b1;
  end
  // start condition: one bit time low, then idle again
  task automatic send_uart();
    @(posedge sys_clk) uart_receive_line <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    uart_receive_line <= 1'b1;
  endtask
  // dominant bit; no bit-time filter inside, so one bit is enough
  task automatic send_can();
    @(posedge sys_clk) first_can_receive_line <= 1'b0;
    repeat (BIT_CYC) @(posedge sys_clk);
    first_can_receive_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_bms_boot_mode_selector.sv
// bench for the boot mode selector
// assumes: 50 MHz clock, checker bound in its own file
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"
// =====================================================================
// bench top
module test_bms_boot_mode_selector;
  logic        sys_clk = 0, resetn = 0, ext_rst = 0;
  logic        strap_hi = 1, strap_lo = 1, wr_en = 0;
  logic [1:0]  wr_addr = 0, chan;
  logic [15:0] wr_data = 0, ref_sig = `BMS_REF_SIG_DEF;
  logic [2:0]  mode;
  logic        uart, can, fetch, start, srst, loop, done;
  int          mismatches = 0, compares = 0;
  always #10 sys_clk = ~sys_clk;
  bms_host_loader bms_host_loader_inst (.sys_clk(sys_clk),
    .uart_receive_line(uart), .first_can_receive_line(can));
  bms_boot_mode_selector bms_boot_mode_selector_inst (.sys_clk(sys_clk),
    .resetn(resetn), .external_reset_input(ext_rst),
    .boot_strap_high(strap_hi), .boot_strap_low(strap_lo),
    .uart_receive_line(uart), .first_can_receive_line(can),
    .ref_signature(ref_sig), .word_wr_en(wr_en), .word_wr_addr(wr_addr),
    .word_wr_data(wr_data), .boot_mode_q(mode),
    .fetch_to_test_flash_q(fetch), .loader_channel_q(chan),
    .loader_start_q(start), .software_reset_q(srst),
    .boot_loop_q(loop), .boot_done_q(done));
  // =====================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [2:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // straps never 00: that pattern is reserved for the strap driver
  task automatic boot(input logic [1:0] s);
    @(posedge sys_clk);
    ext_rst <= 1'b0;
    {strap_hi, strap_lo} <= s;
    cyc(2);
    ext_rst <= 1'b1;
    cyc(1);
    // straps move once the rise is taken; only the latched copy may count
    {strap_hi, strap_lo} <= (s == 2'h3) ? 2'h2 : 2'h3;
    cyc(3);
    #1;
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // =====================================================================
  // scenarios
  task automatic t_user();
    boot(2'h3);
    chk("mode", mode, `BMS_MODE_USER);
    chk("fetch", 3'(fetch), 3'h0);
    chk("done", 3'(done), 3'h1);
    @(posedge sys_clk) {strap_hi, strap_lo} <= 2'h2;
    cyc(4);
    #1;
    chk("held", mode, `BMS_MODE_USER);
  endtask
  // first line to move wins, the later one is ignored
  task automatic t_std(input logic by_uart);
    boot(2'h2);
    chk("mode", mode, `BMS_MODE_STD);
    chk("fetch", 3'(fetch), 3'h1);
    chk("idle", 3'(chan), 3'(`BMS_CHAN_NONE));
    if (by_uart) bms_host_loader_inst.send_uart();
    else bms_host_loader_inst.send_can();
    if (by_uart) bms_host_loader_inst.send_can();
    else bms_host_loader_inst.send_uart();
    #1;
    chk("chan", 3'(chan), by_uart ? 3'h1 : 3'h2);
    chk("done", 3'(done), 3'h1);
  endtask
  // word A equals the reference, word B zero: signature matches
  task automatic t_match();
    logic [2:0] hi;
    hi = 0;
    wr(2'h0, `BMS_REF_SIG_DEF);
    wr(2'h1, 16'h0000);
    boot(2'h1);
    chk("mode", mode, `BMS_MODE_SEL);
    chk("fetch", 3'(fetch), 3'h1);
    repeat (30) begin
      @(posedge sys_clk) #1;
      if (srst === 1'b1 && hi != 3'h7) hi++;
    end
    chk("srst", hi, 3'h4);
    chk("user", {1'b0, done, fetch}, 3'h2);
  endtask
  // bad signature, each key code in turn
  task automatic t_key(input logic [1:0] k);
    wr(2'h0, 16'h0001);
    wr(2'h2, {14'h0, k});
    boot(2'h1);
    cyc(12);
    #1;
    chk("loop", 3'(loop), 3'(k == `BMS_KEY_LOOP));
    if (k != `BMS_KEY_LOOP) begin
      if (k == `BMS_KEY_UART) bms_host_loader_inst.send_can();
      if (k == `BMS_KEY_CAN) bms_host_loader_inst.send_uart();
      #1;
      chk("barred", 3'(chan), 3'h0);
      if (k == `BMS_KEY_CAN) bms_host_loader_inst.send_can();
      else bms_host_loader_inst.send_uart();
      #1;
      chk("key", 3'(chan), k == `BMS_KEY_CAN ? 3'h2 : 3'h1);
    end
  endtask
  // =====================================================================
  // main sequence and watchdog
  initial begin
    cyc(12);
    resetn <= 1'b1;
    t_user();
    t_std(1'b1);
    t_std(1'b0);
    t_match();
    for (int k = 0; k < 4; k++) t_key(2'(k));
    print_verdict();
  end
  // whole run needs well under a thousand cycles
  initial begin
    cyc(5000);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/bms_boot_mode_selector.v
// bms_boot_mode_selector.v: boot mode selection and loader channel choice
// assumes: one 50 MHz clock, straps and receive lines synchronous to it,
// external_reset_input low holds the part in reset, its rise ends it
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"

module bms_boot_mode_selector (
  input  wire                     sys_clk,
  input  wire                     resetn,
  input  wire                     external_reset_input,
  input  wire                     boot_strap_high,
  input  wire                     boot_strap_low,
  input  wire                     uart_receive_line,
  input  wire                     first_can_receive_line,
  input  wire [`BMS_WORD_W-1:0]   ref_signature,
  input  wire                     word_wr_en,
  input  wire [1:0]               word_wr_addr,
  input  wire [`BMS_WORD_W-1:0]   word_wr_data,
  output reg  [2:0]               boot_mode_q,
  output reg                      fetch_to_test_flash_q,
  output reg  [1:0]               loader_channel_q,
  output reg                      loader_start_q,
  output reg                      software_reset_q,
  output reg                      boot_loop_q,
  output reg                      boot_done_q
);

  // ==========================================================
  // states
  localparam [3:0] ST_HOLD  = 4'h0;
  localparam [3:0] ST_DEC   = 4'h1;
  localparam [3:0] ST_SCAN  = 4'h2;
  localparam [3:0] ST_RDA   = 4'h3;
  localparam [3:0] ST_RDB   = 4'h4;
  localparam [3:0] ST_RDK   = 4'h5;
  localparam [3:0] ST_CHK   = 4'h6;
  localparam [3:0] ST_SRST  = 4'h7;
  localparam [3:0] ST_DONE  = 4'h8;
  localparam [3:0] ST_LOOP  = 4'h9;
  localparam [3:0] ST_WAIT  = 4'ha;

  // signature of the two reserved words
  function [`BMS_WORD_W-1:0] sig_of;
    input [`BMS_WORD_W-1:0] a;
    input [`BMS_WORD_W-1:0] b;
    begin
      sig_of = a ^ {b[`BMS_WORD_W-2:0], b[`BMS_WORD_W-1]};
    end
  endfunction

  reg [3:0]             state_q;
  reg [3:0]             state_d;
  reg                   rst_in_q;
  reg [1:0]             strap_q;
  reg [1:0]             rd_addr_q;
  reg [`BMS_WORD_W-1:0] word_a_q;
  reg [`BMS_WORD_W-1:0] word_b_q;
  reg [3:0]             cnt_q;
  reg                   uart_prev_q;
  reg                   can_prev_q;
  reg [1:0]             allow_q;  // bit0 uart allowed, bit1 can allowed
  wire [`BMS_WORD_W-1:0] rd_data;

  wire reset_rise = external_reset_input & ~rst_in_q;
  wire in_reset   = ~external_reset_input;
  // a falling edge (idle high to low) marks a uart start or can dominant bit
  wire uart_start = allow_q[`BMS_ALLOW_UART_BIT] & uart_prev_q &
                    ~uart_receive_line;
  wire can_dom    = allow_q[`BMS_ALLOW_CAN_BIT] & can_prev_q &
                    ~first_can_receive_line;

  bms_word_store bms_word_store_inst (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .wr_en     (word_wr_en),
    .wr_addr   (word_wr_addr),
    .wr_data   (word_wr_data),
    .rd_addr   (rd_addr_q),
    .rd_data_q (rd_data)
  );

  // ==========================================================
  // next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (reset_rise) begin
          state_d = ST_DEC;
        end
      end
      ST_DEC: begin
        case (strap_q)
          `BMS_STRAP_USER: state_d = ST_DONE;
          `BMS_STRAP_STD:  state_d = ST_SCAN;
          `BMS_STRAP_SEL:  state_d = ST_RDA;
          default:         state_d = ST_LOOP;  // reserved strap
        endcase
      end
      ST_SCAN: begin
        if (uart_start || can_dom) begin
          state_d = ST_DONE;
        end
      end
      ST_RDA:  state_d = ST_WAIT;
      ST_WAIT: state_d = ST_RDB;
      ST_RDB:  state_d = ST_RDK;
      ST_RDK:  state_d = ST_CHK;
      ST_CHK: begin
        if (sig_of(word_a_q, word_b_q) == ref_signature) begin
          state_d = ST_SRST;
        end else begin
          case (rd_data[`BMS_KEY_MSB:`BMS_KEY_LSB])
            `BMS_KEY_STD:  state_d = ST_SCAN;
            `BMS_KEY_UART: state_d = ST_SCAN;
            `BMS_KEY_CAN:  state_d = ST_SCAN;
            default:       state_d = ST_LOOP;
          endcase
        end
      end
      ST_SRST: begin
        if (cnt_q == `BMS_CNT_ONE) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: state_d = ST_DONE;
      ST_LOOP: state_d = ST_LOOP;
      default: state_d = ST_HOLD;
    endcase
    // a new external reset always restarts the selection
    if (in_reset) begin
      state_d = ST_HOLD;
    end
  end

  // ==========================================================
  // sequencing and outputs
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q               <= ST_HOLD;
      rst_in_q              <= 1'b0;
      strap_q               <= `BMS_STRAP_USER;
      rd_addr_q             <= `BMS_SIG_ADDR_A;
      word_a_q              <= `BMS_WORD_ZERO;
      word_b_q              <= `BMS_WORD_ZERO;
      cnt_q                 <= `BMS_CNT_ZERO;
      uart_prev_q           <= 1'b1;
      can_prev_q            <= 1'b1;
      allow_q               <= `BMS_ALLOW_ALL;
      boot_mode_q           <= `BMS_MODE_USER;
      fetch_to_test_flash_q <= 1'b0;
      loader_channel_q      <= `BMS_CHAN_NONE;
      loader_start_q        <= 1'b0;
      software_reset_q      <= 1'b0;
      boot_loop_q           <= 1'b0;
      boot_done_q           <= 1'b0;
    end else begin
      state_q        <= state_d;
      rst_in_q       <= external_reset_input;
      uart_prev_q    <= uart_receive_line;
      can_prev_q     <= first_can_receive_line;
      loader_start_q <= 1'b0;
      // straps latched only at the release edge, then held for the run
      if (reset_rise) begin
        strap_q <= {boot_strap_high, boot_strap_low};
      end
      case (state_q)
        ST_HOLD: begin
          boot_done_q      <= 1'b0;
          boot_loop_q      <= 1'b0;
          software_reset_q <= 1'b0;
          loader_channel_q <= `BMS_CHAN_NONE;
          allow_q          <= `BMS_ALLOW_ALL;
          rd_addr_q        <= `BMS_SIG_ADDR_A;
        end
        ST_DEC: begin
          // user flash stays mapped at zero; only fetches move
          case (strap_q)
            `BMS_STRAP_USER: begin
              boot_mode_q           <= `BMS_MODE_USER;
              fetch_to_test_flash_q <= 1'b0;
            end
            `BMS_STRAP_STD: begin
              boot_mode_q           <= `BMS_MODE_STD;
              fetch_to_test_flash_q <= 1'b1;
            end
            `BMS_STRAP_SEL: begin
              boot_mode_q           <= `BMS_MODE_SEL;
              fetch_to_test_flash_q <= 1'b1;
            end
            default: begin
              boot_mode_q           <= `BMS_MODE_RSVD;
              fetch_to_test_flash_q <= 1'b0;
            end
          endcase
        end
        ST_SCAN: begin
          // uart wins a tie: its start bit is the classic entry
          if (uart_start) begin
            loader_channel_q <= `BMS_CHAN_UART;
            loader_start_q   <= 1'b1;
            boot_done_q      <= 1'b1;
          end else if (can_dom) begin
            loader_channel_q <= `BMS_CHAN_CAN;
            loader_start_q   <= 1'b1;
            boot_done_q      <= 1'b1;
          end
        end
        // store read data lags the address by one cycle
        ST_RDA:  rd_addr_q <= `BMS_SIG_ADDR_B;
        ST_WAIT: begin
          word_a_q  <= rd_data;
          rd_addr_q <= `BMS_KEY_ADDR;
        end
        ST_RDB:  word_b_q <= rd_data;
        ST_CHK: begin
          if (state_d == ST_SRST) begin
            software_reset_q <= 1'b1;
            cnt_q            <= `BMS_SRST_CYCLES;
          end else if (state_d == ST_LOOP) begin
            boot_loop_q      <= 1'b1;
          end else begin
            case (rd_data[`BMS_KEY_MSB:`BMS_KEY_LSB])
              `BMS_KEY_UART: allow_q <= `BMS_ALLOW_UART;
              `BMS_KEY_CAN:  allow_q <= `BMS_ALLOW_CAN;
              default:       allow_q <= `BMS_ALLOW_ALL;
            endcase
          end
        end
        ST_SRST: begin
          cnt_q <= cnt_q - `BMS_CNT_ONE;
          if (cnt_q == `BMS_CNT_ONE) begin
            // user code runs with fetches back on user flash
            software_reset_q      <= 1'b0;
            fetch_to_test_flash_q <= 1'b0;
            boot_done_q           <= 1'b1;
          end
        end
        ST_DONE: begin
          if (boot_mode_q == `BMS_MODE_USER) begin
            boot_done_q <= 1'b1;
          end
        end
        ST_LOOP: boot_loop_q <= 1'b1;
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
      if (in_reset) begin
        boot_done_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verilog/bms_defs.vh
// bms_defs.vh: constants for the boot mode selector
// assumes: included by bare name from the design files under verilog/
`ifndef BMS_DEFS_VH
`define BMS_DEFS_VH

// strap decode, {boot_strap_high, boot_strap_low}
`define BMS_STRAP_USER      2'h3
`define BMS_STRAP_STD       2'h2
`define BMS_STRAP_SEL       2'h1
`define BMS_STRAP_RSVD      2'h0

// boot mode codes shown on boot_mode
`define BMS_MODE_USER       3'h0
`define BMS_MODE_STD        3'h1
`define BMS_MODE_SEL        3'h2
`define BMS_MODE_RSVD       3'h3

// loader channel codes shown on loader_channel
`define BMS_CHAN_NONE       2'h0
`define BMS_CHAN_UART       2'h1
`define BMS_CHAN_CAN        2'h2

// user key actions
`define BMS_KEY_STD         2'h0
`define BMS_KEY_UART        2'h1
`define BMS_KEY_CAN         2'h2
`define BMS_KEY_LOOP        2'h3

// key field inside the stored key word
`define BMS_KEY_MSB         1
`define BMS_KEY_LSB         0

// channel permission mask, one bit per loader channel
`define BMS_ALLOW_UART_BIT  0
`define BMS_ALLOW_CAN_BIT   1
`define BMS_ALLOW_ALL       2'h3
`define BMS_ALLOW_UART      2'h1
`define BMS_ALLOW_CAN       2'h2

// reserved signature word addresses and width
`define BMS_SIG_ADDR_A      2'h0
`define BMS_SIG_ADDR_B      2'h1
`define BMS_KEY_ADDR        2'h2
`define BMS_WORD_W          16
`define BMS_WORDS           4
`define BMS_WORD_ZERO       16'h0000
`define BMS_REF_SIG_DEF     16'ha55a

// width of the software reset pulse, in cycles
`define BMS_SRST_CYCLES     4'h4
`define BMS_CNT_ZERO        4'h0
`define BMS_CNT_ONE         4'h1

`endif

// ===== verilog/bms_word_store.v
// bms_word_store.v: little store of the reserved boot words
// assumes: one clock, words written by the flash loading path, read back
// through a registered output one cycle after the address is given
`timescale 1ns/1ps
`default_nettype none
`include "bms_defs.vh"

module bms_word_store (
  input  wire                     sys_clk,
  input  wire                     resetn,
  input  wire                     wr_en,
  input  wire [1:0]               wr_addr,
  input  wire [`BMS_WORD_W-1:0]   wr_data,
  input  wire [1:0]               rd_addr,
  output reg  [`BMS_WORD_W-1:0]   rd_data_q
);

  reg [`BMS_WORD_W-1:0] mem [0:`BMS_WORDS-1];
  integer i;

  // ==========================================================
  // storage and registered read
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rd_data_q <= `BMS_WORD_ZERO;
      for (i = 0; i < `BMS_WORDS; i = i + 1) begin
        mem[i] <= `BMS_WORD_ZERO;
      end
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire
